// File: src/custom_a_ref_monitor_limits.v
// custom A reference monitor register bank with AXI4-Lite access
`timescale 1ns/10ps
`include "ref_mon_consts.vh"

module custom_a_ref_monitor_limits
(
    input wire aclk,
    input wire aresetn,
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire ref_clk_in,
    output reg [1:0] ref_freq_mode,
    output reg [7:0] custom_a_freq_multiple_lo,
    output reg [5:0] custom_a_freq_multiple_hi,
    output reg [7:0] custom_a_period_low_bound,
    output reg [7:0] custom_a_period_high_bound,
    output reg [7:0] custom_a_freq_low_bound_lo,
    output reg [7:0] custom_a_freq_low_bound_hi,
    output reg [7:0] custom_a_freq_high_bound_lo,
    output reg [7:0] custom_a_freq_high_bound_hi,
    output reg [7:0] custom_a_window_cycles,
    output reg custom_a_divide_by_four,
    output wire period_fail,
    output wire freq_fail,
    output wire ref_fail
);

// ==========================================================================
// write channel holding registers
reg [11:0] awaddr_q;
reg aw_have_q;
reg [7:0] wbyte_q;
reg wlane0_q;
reg w_have_q;
wire [7:0] widx;
wire wtop_ok;
reg wmapped;
wire [7:0] ridx;
wire rtop_ok;
reg [31:0] rdata_d;
reg rmapped;
wire do_write;

assign widx = awaddr_q[`IDX_MSB:`IDX_LSB];
assign wtop_ok = (awaddr_q[`ADDR_TOP_MSB:`ADDR_TOP_LSB] == `ADDR_TOP_ZERO);
assign ridx = s_axi_araddr[`IDX_MSB:`IDX_LSB];
assign rtop_ok =
    (s_axi_araddr[`ADDR_TOP_MSB:`ADDR_TOP_LSB] == `ADDR_TOP_ZERO);
assign do_write = aw_have_q & w_have_q & ~s_axi_bvalid;

// ==========================================================================
// write decode
always @*
begin
    case (widx)
        `IDX_REF_FREQ_MODE, `IDX_MULT_LO, `IDX_MULT_HI,
        `IDX_PERIOD_LOW, `IDX_PERIOD_HIGH, `IDX_FREQ_LOW_LO,
        `IDX_FREQ_LOW_HI, `IDX_FREQ_HIGH_LO, `IDX_FREQ_HIGH_HI,
        `IDX_WINDOW_CYCLES, `IDX_DIVIDE:
            wmapped = wtop_ok;
        default:
            wmapped = 1'b0;
    endcase
end

// ==========================================================================
// write channels: address and data taken in either order
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `RESP_OKAY;
        awaddr_q <= 12'h000;
        aw_have_q <= 1'b0;
        wbyte_q <= `BYTE_ZERO;
        wlane0_q <= 1'b0;
        w_have_q <= 1'b0;
    end
    else
    begin
        if (s_axi_awvalid && s_axi_awready)
        begin
            awaddr_q <= s_axi_awaddr;
            aw_have_q <= 1'b1;
            s_axi_awready <= 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            wbyte_q <= s_axi_wdata[7:0];
            wlane0_q <= s_axi_wstrb[0];
            w_have_q <= 1'b1;
            s_axi_wready <= 1'b0;
        end
        if (do_write)
        begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wmapped ? `RESP_OKAY : `RESP_SLVERR;
        end
        // one write at a time: reopen only once the response is taken
        if (s_axi_bvalid && s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end
    end
end

// ==========================================================================
// configuration registers; only byte lane 0 carries data
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        ref_freq_mode <= `MODE_RESET;
        custom_a_freq_multiple_lo <= `BYTE_ZERO;
        custom_a_freq_multiple_hi <= `MULT_HI_RESET;
        custom_a_period_low_bound <= `BYTE_ZERO;
        custom_a_period_high_bound <= `BYTE_ZERO;
        custom_a_freq_low_bound_lo <= `BYTE_ZERO;
        custom_a_freq_low_bound_hi <= `BYTE_ZERO;
        custom_a_freq_high_bound_lo <= `BYTE_ZERO;
        custom_a_freq_high_bound_hi <= `BYTE_ZERO;
        custom_a_window_cycles <= `BYTE_ZERO;
        custom_a_divide_by_four <= `DIV_RESET;
    end
    else if (do_write && wmapped && wlane0_q)
    begin
        case (widx)
            `IDX_REF_FREQ_MODE:
                ref_freq_mode <= wbyte_q[`MODE_W-1:0];
            `IDX_MULT_LO:
                custom_a_freq_multiple_lo <= wbyte_q;
            `IDX_MULT_HI:
                custom_a_freq_multiple_hi <= wbyte_q[`MULT_HI_W-1:0];
            `IDX_PERIOD_LOW:
                custom_a_period_low_bound <= wbyte_q;
            `IDX_PERIOD_HIGH:
                custom_a_period_high_bound <= wbyte_q;
            `IDX_FREQ_LOW_LO:
                custom_a_freq_low_bound_lo <= wbyte_q;
            `IDX_FREQ_LOW_HI:
                custom_a_freq_low_bound_hi <= wbyte_q;
            `IDX_FREQ_HIGH_LO:
                custom_a_freq_high_bound_lo <= wbyte_q;
            `IDX_FREQ_HIGH_HI:
                custom_a_freq_high_bound_hi <= wbyte_q;
            `IDX_WINDOW_CYCLES:
                custom_a_window_cycles <= wbyte_q;
            `IDX_DIVIDE:
                custom_a_divide_by_four <= wbyte_q[0];
            default:
                custom_a_divide_by_four <= custom_a_divide_by_four;
        endcase
    end
end

// ==========================================================================
// read decode; reserved bits read as zero
always @*
begin
    rdata_d = `DATA_ZERO;
    rmapped = rtop_ok;
    case (ridx)
        `IDX_REF_FREQ_MODE:
            rdata_d[`MODE_W-1:0] = ref_freq_mode;
        `IDX_MULT_LO:
            rdata_d[7:0] = custom_a_freq_multiple_lo;
        `IDX_MULT_HI:
            rdata_d[`MULT_HI_W-1:0] = custom_a_freq_multiple_hi;
        `IDX_PERIOD_LOW:
            rdata_d[7:0] = custom_a_period_low_bound;
        `IDX_PERIOD_HIGH:
            rdata_d[7:0] = custom_a_period_high_bound;
        `IDX_FREQ_LOW_LO:
            rdata_d[7:0] = custom_a_freq_low_bound_lo;
        `IDX_FREQ_LOW_HI:
            rdata_d[7:0] = custom_a_freq_low_bound_hi;
        `IDX_FREQ_HIGH_LO:
            rdata_d[7:0] = custom_a_freq_high_bound_lo;
        `IDX_FREQ_HIGH_HI:
            rdata_d[7:0] = custom_a_freq_high_bound_hi;
        `IDX_WINDOW_CYCLES:
            rdata_d[7:0] = custom_a_window_cycles;
        `IDX_DIVIDE:
            rdata_d[0] = custom_a_divide_by_four;
        `IDX_STATUS:
            rdata_d[2:0] = {freq_fail, period_fail, ref_fail};
        default:
            rmapped = 1'b0;
    endcase
    if (!rmapped)
        rdata_d = `DATA_ZERO;
end

// ==========================================================================
// read channel: answer one cycle after the address is taken
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= `DATA_ZERO;
        s_axi_rresp <= `RESP_OKAY;
    end
    else
    begin
        if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdata_d;
            s_axi_rresp <= rmapped ? `RESP_OKAY : `RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
end

// ==========================================================================
// limit checker fed from the bank
ref_limit_check u_limit_check
(
    .aclk(aclk),
    .aresetn(aresetn),
    .ref_clk_in(ref_clk_in),
    .mode(ref_freq_mode),
    .period_low(custom_a_period_low_bound),
    .period_high(custom_a_period_high_bound),
    .freq_low({custom_a_freq_low_bound_hi, custom_a_freq_low_bound_lo}),
    .freq_high({custom_a_freq_high_bound_hi, custom_a_freq_high_bound_lo}),
    .window_cycles(custom_a_window_cycles),
    .divide_by_four(custom_a_divide_by_four),
    .period_fail_q(period_fail),
    .freq_fail_q(freq_fail),
    .ref_fail_q(ref_fail)
);

endmodule // custom_a_ref_monitor_limits

// File: src/ref_limit_check.v
// period and windowed-frequency limit checker for custom configuration A
`timescale 1ns/10ps
`include "ref_mon_consts.vh"

module ref_limit_check
(
    input wire aclk,
    input wire aresetn,
    input wire ref_clk_in,
    input wire [1:0] mode,
    input wire [7:0] period_low,
    input wire [7:0] period_high,
    input wire [15:0] freq_low,
    input wire [15:0] freq_high,
    input wire [7:0] window_cycles,
    input wire divide_by_four,
    output reg period_fail_q,
    output reg freq_fail_q,
    output reg ref_fail_q
);

// ==========================================================================
// reference input synchroniser and edge detect
reg sync1_q;
reg sync2_q;
reg sync3_q;
wire ref_edge;
wire active;
reg [1:0] div_cnt_q;
wire ref_tick;
reg [7:0] per_cnt_q;
reg per_primed_q;
reg [15:0] clk_cnt_q;
reg [7:0] win_cnt_q;
reg win_primed_q;
reg period_fail_d;
reg freq_fail_d;

assign ref_edge = sync2_q & ~sync3_q;
// limits only take effect in custom A mode
assign active = (mode == `MODE_CUSTOM_A);
// longer window for fast references
assign ref_tick = ref_edge & (~divide_by_four | (div_cnt_q == `DIV4_LAST));

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        sync1_q <= 1'b0;
        sync2_q <= 1'b0;
        sync3_q <= 1'b0;
    end
    else
    begin
        sync1_q <= ref_clk_in;
        sync2_q <= sync1_q;
        sync3_q <= sync2_q;
    end
end

// ==========================================================================
// fail decisions
always @*
begin
    period_fail_d = period_fail_q;
    freq_fail_d = freq_fail_q;
    if (!active)
    begin
        period_fail_d = 1'b0;
        freq_fail_d = 1'b0;
    end
    else
    begin
        // a stalled reference counts as too long a period
        if (ref_edge && per_primed_q)
            period_fail_d = (per_cnt_q < period_low) ||
                (per_cnt_q > period_high);
        else if (per_primed_q && per_cnt_q == `PERIOD_MAX)
            period_fail_d = 1'b1;
        // >= so a window shortened by software closes at the next tick
        if (ref_tick && win_primed_q && win_cnt_q >= window_cycles)
            freq_fail_d = (clk_cnt_q < freq_low) ||
                (clk_cnt_q > freq_high);
    end
end

// ==========================================================================
// counters
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        div_cnt_q <= 2'h0;
        per_cnt_q <= `BYTE_ZERO;
        per_primed_q <= 1'b0;
        clk_cnt_q <= 16'h0000;
        win_cnt_q <= `BYTE_ZERO;
        win_primed_q <= 1'b0;
        period_fail_q <= 1'b0;
        freq_fail_q <= 1'b0;
        ref_fail_q <= 1'b0;
    end
    else
    begin
        period_fail_q <= period_fail_d;
        freq_fail_q <= freq_fail_d;
        ref_fail_q <= period_fail_d | freq_fail_d;
        if (!active)
        begin
            div_cnt_q <= 2'h0;
            per_primed_q <= 1'b0;
            win_primed_q <= 1'b0;
            win_cnt_q <= `BYTE_ZERO;
        end
        else
        begin
            if (ref_edge)
                div_cnt_q <= div_cnt_q + 2'h1;
            if (ref_edge)
            begin
                per_cnt_q <= `PERIOD_ONE;
                per_primed_q <= 1'b1;
            end
            else if (per_cnt_q != `PERIOD_MAX)
                per_cnt_q <= per_cnt_q + `PERIOD_ONE;
            // window spans stored count plus one ticks
            if (ref_tick && (!win_primed_q || win_cnt_q >= window_cycles))
            begin
                win_primed_q <= 1'b1;
                win_cnt_q <= `BYTE_ZERO;
                clk_cnt_q <= `COUNT_ONE;
            end
            else
            begin
                if (ref_tick)
                    win_cnt_q <= win_cnt_q + `PERIOD_ONE;
                if (clk_cnt_q != `COUNT_MAX)
                    clk_cnt_q <= clk_cnt_q + `COUNT_ONE;
            end
        end
    end
end

endmodule // ref_limit_check

// File: src/ref_mon_consts.vh
// register indices, reset values and field layout of the custom A bank
`ifndef REF_MON_CONSTS_VH
`define REF_MON_CONSTS_VH

// ==========================================================================
// register indices (byte address is four times the index)
`define IDX_REF_FREQ_MODE 8'h65
`define IDX_MULT_LO 8'h67
`define IDX_MULT_HI 8'h68
`define IDX_PERIOD_LOW 8'h69
`define IDX_PERIOD_HIGH 8'h6A
`define IDX_FREQ_LOW_LO 8'h6B
`define IDX_FREQ_LOW_HI 8'h6C
`define IDX_FREQ_HIGH_LO 8'h6D
`define IDX_FREQ_HIGH_HI 8'h6E
`define IDX_WINDOW_CYCLES 8'h6F
`define IDX_DIVIDE 8'h70
`define IDX_STATUS 8'h80

// ==========================================================================
// address decode
`define ADDR_W 12
`define IDX_MSB 9
`define IDX_LSB 2
`define ADDR_TOP_MSB 11
`define ADDR_TOP_LSB 10
`define ADDR_TOP_ZERO 2'h0

// ==========================================================================
// field widths and reset values
`define MODE_W 2
`define MULT_HI_W 6
`define BYTE_ZERO 8'h00
`define MODE_RESET 2'h0
`define MULT_HI_RESET 6'h00
`define DIV_RESET 1'b0
`define MODE_AUTO 2'h0
`define MODE_CUSTOM_A 2'h1
`define MODE_CUSTOM_B 2'h2

// ==========================================================================
// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define DATA_ZERO 32'h0000_0000

// ==========================================================================
// monitor counters
`define DIV4_LAST 2'h3
`define PERIOD_MAX 8'hFF
`define PERIOD_ONE 8'h01
`define COUNT_MAX 16'hFFFF
`define COUNT_ONE 16'h0001

`endif

// File: test/custom_a_ref_monitor_limits_props.sv
// assertion checker for the custom A limit register bank
`timescale 1ns/10ps
module ref_mon_props
(
    input logic aclk,
    input logic aresetn,
    input logic [11:0] s_axi_awaddr,
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic [31:0] s_axi_wdata,
    input logic [3:0] s_axi_wstrb,
    input logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic [1:0] s_axi_bresp,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    input logic [1:0] ref_freq_mode,
    input logic [7:0] custom_a_period_low_bound,
    input logic [7:0] custom_a_period_high_bound,
    input logic [7:0] custom_a_freq_low_bound_hi,
    input logic [7:0] custom_a_freq_high_bound_hi,
    input logic [7:0] custom_a_window_cycles,
    input logic period_fail,
    input logic freq_fail,
    input logic ref_fail
);
// ==========================================================================
// bus timing and stored limits
default clocking @(posedge aclk); endclocking
default disable iff (!aresetn);
wire aw_w = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
property p_store(a, q);
    aw_w && s_axi_awaddr == a && s_axi_wstrb[0]
        |=> ##1 q == $past(s_axi_wdata[7:0], 2);
endproperty
a_write_answer: assert property (aw_w |=> ##1 s_axi_bvalid)
    else $error("write answer missing");
a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && !s_axi_arready) else $error("read answer missing");
a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
a_period_low_store:
    assert property (p_store(12'h1A4, custom_a_period_low_bound))
    else $error("period low bound not stored");
a_period_high_store:
    assert property (p_store(12'h1A8, custom_a_period_high_bound))
    else $error("period high bound not stored");
a_freq_low_upper:
    assert property (p_store(12'h1B0, custom_a_freq_low_bound_hi))
    else $error("freq low upper byte not stored");
a_freq_high_upper:
    assert property (p_store(12'h1B8, custom_a_freq_high_bound_hi))
    else $error("freq high upper byte not stored");
a_window_store:
    assert property (p_store(12'h1BC, custom_a_window_cycles))
    else $error("window cycles not stored");
a_idle_mode_quiet: assert property (ref_freq_mode != 2'h1
    |=> !period_fail && !freq_fail && !ref_fail) else $error("flag in idle");
cover property (aw_w && s_axi_awaddr == 12'h1BC);
cover property (s_axi_bvalid && !s_axi_bready);
cover property (ref_fail && ref_freq_mode == 2'h1);
endmodule // ref_mon_props

bind custom_a_ref_monitor_limits ref_mon_props u_props
(
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .ref_freq_mode,
    .custom_a_period_low_bound, .custom_a_period_high_bound,
    .custom_a_freq_low_bound_hi, .custom_a_freq_high_bound_hi,
    .custom_a_window_cycles, .period_fail, .freq_fail, .ref_fail
);

// File: test/tb.sv
// self-checking bench for the custom A limit register bank
`timescale 1ns/10ps
module tb;
reg aclk = 1'h0;
reg ref_clk_in = 1'h0;
reg aresetn, awvalid, wvalid, bready, arvalid, rready;
reg [11:0] awaddr, araddr;
reg [31:0] wdata;
reg [3:0] wstrb;
wire awready, wready, bvalid, arready, rvalid, div, pf, ff, rf;
wire [1:0] bresp, rresp, mode;
wire [31:0] rdata;
wire [7:0] mlo, plo, phi, fll, flh, fhl, fhh, cyc;
wire [5:0] mhi;
integer err_total, cmp_count, i;
integer half = 5;

custom_a_ref_monitor_limits DUT
(
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ref_clk_in(ref_clk_in),
    .ref_freq_mode(mode), .custom_a_freq_multiple_lo(mlo),
    .custom_a_freq_multiple_hi(mhi), .custom_a_period_low_bound(plo),
    .custom_a_period_high_bound(phi), .custom_a_freq_low_bound_lo(fll),
    .custom_a_freq_low_bound_hi(flh), .custom_a_freq_high_bound_lo(fhl),
    .custom_a_freq_high_bound_hi(fhh), .custom_a_window_cycles(cyc),
    .custom_a_divide_by_four(div), .period_fail(pf), .freq_fail(ff),
    .ref_fail(rf)
);

// ==========================================================================
// clocks and tasks
initial
begin
    forever #4 aclk = ~aclk;
end

// reference period is 2*half aclk cycles
always
begin
    repeat (half) @(posedge aclk);
    ref_clk_in <= ~ref_clk_in;
end

task chk(input [31:0] seen, input [31:0] exp);
    begin
        cmp_count = cmp_count + 1;
        if (seen !== exp)
        begin
            err_total = err_total + 1;
            $display("BAD %0t saw %h expected %h", $time, seen, exp);
        end
    end
endtask

// st: cycles of bready stall
task wr(input [11:0] a, input [7:0] d, input [3:0] s, input [1:0] er,
    input integer st);
    integer n;
    reg done;
    begin
        done = 0;
        awaddr <= a;
        wdata <= {24'h000000, d};
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= (st == 0);
        for (n = 0; n < 60 && !done; n = n + 1)
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (bvalid && bready)
            begin
                done = 1;
                chk(bresp, er);
            end
            else if (n + 1 >= st) bready <= 1'h1;
        end
        if (!done)
        begin
            err_total = err_total + 1;
            final_report;
        end
    end
endtask

task w(input [11:0] a, input [7:0] d);
    wr(a, d, 4'hF, 2'h0, 0);
endtask

task rd(input [11:0] a, input [31:0] ed, input [1:0] er, input integer st);
    integer n;
    reg done;
    begin
        done = 0;
        araddr <= a;
        arvalid <= 1'h1;
        rready <= (st == 0);
        for (n = 0; n < 60 && !done; n = n + 1)
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
            if (rvalid && rready)
            begin
                done = 1;
                chk(rdata, ed);
                chk(rresp, er);
            end
            else if (n + 1 >= st) rready <= 1'h1;
        end
        if (!done)
        begin
            err_total = err_total + 1;
            final_report;
        end
    end
endtask

task final_report;
    begin
        $display("mismatches %0d compares %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
endtask

// ==========================================================================
// sequence
initial
begin
    repeat (20000) @(posedge aclk);
    err_total = err_total + 1;
    final_report;
end

initial
begin
    err_total = 0;
    cmp_count = 0;
    aresetn = 1'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h00000000;
    wstrb = 4'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    // index 0x66 is a hole in the map
    for (i = 8'h65; i <= 8'h70; i = i + 1)
        rd({2'h0, i[7:0], 2'h0}, 32'h0, (i == 8'h66) ? 2'h2 : 2'h0, 0);
    for (i = 8'h69; i <= 8'h6F; i = i + 1)
        wr({2'h0, i[7:0], 2'h0}, i[7:0] ^ 8'hA5, 4'hF, 2'h0, i - 8'h69);
    for (i = 8'h69; i <= 8'h6F; i = i + 1)
        rd({2'h0, i[7:0], 2'h0}, i[7:0] ^ 8'hA5, 2'h0, i - 8'h69);
    chk({plo, phi, fll, flh}, 32'hCCCFCEC9);
    chk({fhl, fhh, cyc}, 24'hC8CBCA);
    wr(12'h1A4, 8'h00, 4'h0, 2'h0, 0);
    wr(12'hDA4, 8'h55, 4'hF, 2'h2, 0);
    rd(12'h1A4, 32'hCC, 2'h0, 2);
    w(12'h19C, 8'h5A);
    w(12'h1A0, 8'hFF);
    rd(12'h1A0, 32'h3F, 2'h0, 0);
    chk({mhi, mlo}, 14'h3F5A);
    // period 10, window of 2 edges counts 20 against 15..25
    w(12'h1A4, 8'h04);
    w(12'h1A8, 8'h14);
    w(12'h1AC, 8'h0F);
    w(12'h1B0, 8'h00);
    w(12'h1B4, 8'h19);
    w(12'h1B8, 8'h00);
    w(12'h1BC, 8'h01);
    w(12'h194, 8'h01);
    repeat (200) @(posedge aclk);
    chk({rf, pf, ff}, 3'h0);
    w(12'h1BC, 8'h00);
    repeat (200) @(posedge aclk);
    chk({rf, pf, ff}, 3'h5);
    w(12'h1BC, 8'h01);
    half = 15;
    repeat (300) @(posedge aclk);
    chk({rf, pf, ff}, 3'h7);
    // reserved mode is stored but keeps the monitor idle
    w(12'h194, 8'h03);
    rd(12'h194, 32'h3, 2'h0, 0);
    chk({rf, pf, ff}, 3'h0);
    w(12'h194, 8'h01);
    repeat (300) @(posedge aclk);
    chk({rf, pf, ff}, 3'h7);
    w(12'h194, 8'h00);
    repeat (2) @(posedge aclk);
    chk({rf, pf, ff}, 3'h0);
    // divided window: 4 edges of 10 counts 40 against 35..45
    half = 5;
    w(12'h1BC, 8'h00);
    w(12'h1AC, 8'h23);
    w(12'h1B4, 8'h2D);
    w(12'h1C0, 8'h01);
    w(12'h194, 8'h01);
    repeat (300) @(posedge aclk);
    chk({rf, pf, ff}, 3'h0);
    final_report;
end
endmodule // tb
